/* design/lih_pkg.sv */
/*
  Constants for the laser I/O handshake sequencer: register map, field
  positions, reset values and timing counts.
  Assumes a 40 MHz system clock.
*/
package lih_pkg;

  // ==========================================================
  // Clock and timebase
  // ==========================================================
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned TICK_US     = 100;
  localparam int unsigned TICK_CYC    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned OSC_DLY_US  = 60;
  localparam int unsigned OSC_DLY_CYC = CLK_HZ / 1_000_000 * OSC_DLY_US;

  // Acceptance times in ticks of 0.1 ms
  localparam logic [8:0] ACC_T_0P1 = 9'h001;
  localparam logic [8:0] ACC_T_1   = 9'h00a;
  localparam logic [8:0] ACC_T_2   = 9'h014;
  localparam logic [8:0] ACC_T_4   = 9'h028;
  localparam logic [8:0] ACC_T_8   = 9'h050;
  localparam logic [8:0] ACC_T_16  = 9'h0a0;

  // Pulse widths in ticks of 0.1 ms
  localparam logic [8:0] PW_T_16 = 9'h0a0;
  localparam logic [8:0] PW_T_20 = 9'h0c8;
  localparam logic [8:0] PW_T_30 = 9'h12c;
  localparam logic [8:0] PW_T_40 = 9'h190;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_LIMITS = 4'h4;
  localparam logic [3:0] ADDR_COOL   = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  localparam int unsigned CTRL_PUMP   = 0;
  localparam int unsigned CTRL_REPEAT = 1;
  localparam int unsigned CTRL_TWO    = 2;
  localparam int unsigned CTRL_COND   = 3;
  localparam int unsigned CTRL_ACC_LO = 4;
  localparam int unsigned CTRL_PW_LO  = 8;
  localparam int unsigned CTRL_W      = 10;

  localparam logic [9:0]  CTRL_RST   = 10'h030;
  localparam logic [31:0] LIMITS_RST = 32'hffff_0000;
  localparam logic [15:0] COOL_RST   = 16'h0000;

  localparam logic [2:0] ACC_SEL_0P1 = 3'h0;
  localparam logic [2:0] ACC_SEL_1   = 3'h1;
  localparam logic [2:0] ACC_SEL_2   = 3'h2;
  localparam logic [2:0] ACC_SEL_8   = 3'h4;
  localparam logic [2:0] ACC_SEL_16  = 3'h5;

  localparam logic [1:0] PW_SEL_30 = 2'h1;
  localparam logic [1:0] PW_SEL_40 = 2'h2;

  typedef enum logic [1:0] {
    LIH_IDLE,
    LIH_DELAY,
    LIH_LASE,
    LIH_END
  } lih_state_e;

endpackage : lih_pkg

/* design/lih_top.sv */
/*
  Laser I/O handshake sequencer: control mode, start/stop, ready,
  acceptance filters, end and judgment pulses, Wishbone registers.
  Assumes contact inputs already debounced and synchronous to clk_i,
  closed contact = 1.
*/
// The Wishbone interface to the registers and the address map were left to the implementer.
// Function
// - Open mode input panel, closed external
// - External: start with stop closed; stop ends
// - Panel button toggles output on and off
// - Pump-on only when module warm enough
// - Ready after preparation; repeat cooldown holds off
// - No valid schedule keeps ready off
// - Single-beam pulses 20 ms, or 30/40
// - Monitor output shows energy within limits
// - Schedule and start need acceptance time
// - Oscillation 50-100 us after start accepted
// - Two-beam ready waits for conditional input
// - Two-beam pulses 16 ms, or 30/40
// - Single-beam variant ignores beam select
`timescale 1ns/1ps
`default_nettype none

module lih_top #(
  parameter int unsigned TICK_CYC    = lih_pkg::TICK_CYC,
  parameter int unsigned OSC_DLY_CYC = lih_pkg::OSC_DLY_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ctrl_ext_i,
  input  wire logic        start_i,
  input  wire logic        stop_i,
  input  wire logic        panel_btn_i,
  input  wire logic        schedule_i,
  input  wire logic        beam_sel_i,
  input  wire logic        single_variant_i,
  input  wire logic        temp_ok_i,
  input  wire logic [15:0] energy_i,
  output logic             pump_diode_source_on_o,
  output logic             ready_o,
  output logic             laser_on_o,
  output logic             output_path_one_o,
  output logic             output_path_two_o,
  output logic             end_pulse_o,
  output logic             pass_pulse_o,
  output logic             fail_pulse_o,
  output logic             energy_ok_o
);

  // ==========================================================
  // Registers
  // ==========================================================
  logic [9:0]  ctrl;
  logic [31:0] limits;
  logic [15:0] cool_reg;
  logic [15:0] energy_q;
  logic [31:0] status;
  logic        bus_req;

  lih_pkg::lih_state_e state;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl     <= lih_pkg::CTRL_RST;
      limits   <= lih_pkg::LIMITS_RST;
      cool_reg <= lih_pkg::COOL_RST;
    end
    else if (bus_req && wb_we_i)
    begin
      if (wb_adr_i == lih_pkg::ADDR_CTRL)
      begin
        if (wb_sel_i[0])
          ctrl[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          ctrl[9:8] <= wb_dat_i[9:8];
      end
      if (wb_adr_i == lih_pkg::ADDR_LIMITS)
      begin
        for (int b = 0; b < 4; b++)
          if (wb_sel_i[b])
            limits[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
      end
      if (wb_adr_i == lih_pkg::ADDR_COOL)
      begin
        if (wb_sel_i[0])
          cool_reg[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          cool_reg[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      case (wb_adr_i)
        lih_pkg::ADDR_CTRL:   wb_dat_o <= {22'h00_0000, ctrl};
        lih_pkg::ADDR_LIMITS: wb_dat_o <= limits;
        lih_pkg::ADDR_COOL:   wb_dat_o <= {16'h0000, cool_reg};
        lih_pkg::ADDR_STATUS: wb_dat_o <= status;
        default:              wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Timebase and selections
  // ==========================================================
  logic [15:0] tick_cnt;
  logic        tick;
  logic [8:0]  acc_ticks;
  logic [8:0]  pw_ticks;
  logic        ext_mode;
  logic        two_beam;

  assign tick     = (tick_cnt == 16'(TICK_CYC - 1));
  assign ext_mode = ctrl_ext_i;
  assign two_beam = ctrl[lih_pkg::CTRL_TWO] && !single_variant_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end

  always_comb
  begin
    case (ctrl[lih_pkg::CTRL_ACC_LO +: 3])
      lih_pkg::ACC_SEL_0P1: acc_ticks = lih_pkg::ACC_T_0P1;
      lih_pkg::ACC_SEL_1:   acc_ticks = lih_pkg::ACC_T_1;
      lih_pkg::ACC_SEL_2:   acc_ticks = lih_pkg::ACC_T_2;
      lih_pkg::ACC_SEL_8:   acc_ticks = lih_pkg::ACC_T_8;
      lih_pkg::ACC_SEL_16:  acc_ticks = lih_pkg::ACC_T_16;
      default:              acc_ticks = lih_pkg::ACC_T_4;
    endcase
    case (ctrl[lih_pkg::CTRL_PW_LO +: 2])
      lih_pkg::PW_SEL_30: pw_ticks = lih_pkg::PW_T_30;
      lih_pkg::PW_SEL_40: pw_ticks = lih_pkg::PW_T_40;
      default:            pw_ticks = two_beam ? lih_pkg::PW_T_16 : lih_pkg::PW_T_20;
    endcase
  end

  // ==========================================================
  // Acceptance filters: 0 schedule, 1 start
  // ==========================================================
  logic [1:0] raw;
  logic [1:0] acc;
  logic [8:0] flt_cnt [2];

  assign raw[0] = schedule_i;
  assign raw[1] = start_i && stop_i && ext_mode;

  for (genvar g = 0; g < 2; g++)
  begin : g_flt
    always_ff @(posedge clk_i)
    begin
      if (rst_i || !raw[g])
      begin
        flt_cnt[g] <= 9'h000;
        acc[g]     <= 1'b0;
      end
      else
      begin
        if (tick && flt_cnt[g] < acc_ticks)
          flt_cnt[g] <= flt_cnt[g] + 9'h001;
        acc[g] <= (flt_cnt[g] >= acc_ticks);
      end
    end

    a_accept_time: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(acc[g]) |-> $past(flt_cnt[g]) >= acc_ticks && $past(raw[g]))
      else $error("input accepted before acceptance time");
  end

  // ==========================================================
  // Edges and stop conditions
  // ==========================================================
  logic btn_q;
  logic start_q;
  logic mode_q;
  logic btn_rise;
  logic go;
  logic stop_now;

  assign btn_rise = panel_btn_i && !btn_q;
  assign go       = ext_mode ? (acc[1] && !start_q) : btn_rise;
  assign stop_now = (ext_mode != mode_q) || (ext_mode ? !stop_i : btn_rise);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      btn_q   <= 1'b0;
      start_q <= 1'b0;
      mode_q  <= 1'b0;
    end
    else
    begin
      btn_q   <= panel_btn_i;
      start_q <= acc[1];
      mode_q  <= ext_mode;
    end
  end

  // ==========================================================
  // Output sequence
  // ==========================================================
  logic [11:0] dly_cnt;
  logic [8:0]  pw_cnt;
  logic [15:0] cool_cnt;
  logic        in_limits;

  assign in_limits = (energy_i >= limits[15:0]) && (energy_i <= limits[31:16]);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state       <= lih_pkg::LIH_IDLE;
      laser_on_o  <= 1'b0;
      end_pulse_o <= 1'b0;
      dly_cnt     <= 12'h000;
      pw_cnt      <= 9'h000;
      energy_q    <= 16'h0000;
      energy_ok_o <= 1'b0;
    end
    else
    begin
      case (state)
        lih_pkg::LIH_IDLE:
        begin
          if (go && ready_o)
          begin
            state   <= lih_pkg::LIH_DELAY;
            dly_cnt <= 12'(OSC_DLY_CYC - 1);
          end
        end
        lih_pkg::LIH_DELAY:
        begin
          if (stop_now)
            state <= lih_pkg::LIH_IDLE;
          else if (dly_cnt == 12'h000)
          begin
            state      <= lih_pkg::LIH_LASE;
            laser_on_o <= 1'b1;
          end
          else
            dly_cnt <= dly_cnt - 12'h001;
        end
        lih_pkg::LIH_LASE:
        begin
          if (stop_now)
          begin
            state       <= lih_pkg::LIH_END;
            laser_on_o  <= 1'b0;
            end_pulse_o <= 1'b1;
            pw_cnt      <= pw_ticks;
            energy_q    <= energy_i;
            energy_ok_o <= in_limits;
          end
        end
        lih_pkg::LIH_END:
        begin
          if (pw_cnt == 9'h000)
          begin
            state       <= lih_pkg::LIH_IDLE;
            end_pulse_o <= 1'b0;
          end
          else if (tick)
            pw_cnt <= pw_cnt - 9'h001;
        end
        default:
          state <= lih_pkg::LIH_IDLE;
      endcase
    end
  end

  assign pass_pulse_o = end_pulse_o && energy_ok_o;
  assign fail_pulse_o = end_pulse_o && !energy_ok_o;

  // ==========================================================
  // Pump, cooldown, ready, beam paths
  // ==========================================================
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cool_cnt <= 16'h0000;
    else if (state == lih_pkg::LIH_LASE && stop_now && ctrl[lih_pkg::CTRL_REPEAT])
      cool_cnt <= cool_reg;
    else if (tick && cool_cnt != 16'h0000)
      cool_cnt <= cool_cnt - 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pump_diode_source_on_o <= 1'b0;
      ready_o                <= 1'b0;
      output_path_one_o      <= 1'b0;
      output_path_two_o      <= 1'b0;
    end
    else
    begin
      pump_diode_source_on_o <= ctrl[lih_pkg::CTRL_PUMP] && temp_ok_i;
      ready_o <= pump_diode_source_on_o && acc[0]
                 && !(two_beam && !ctrl[lih_pkg::CTRL_COND])
                 && cool_cnt == 16'h0000
                 && state == lih_pkg::LIH_IDLE;
      output_path_one_o <= single_variant_i || !beam_sel_i;
      output_path_two_o <= !single_variant_i && beam_sel_i;
    end
  end

  assign status = {energy_q, 9'h000, cool_cnt != 16'h0000, energy_ok_o,
                   acc[0], ext_mode, laser_on_o, ready_o, pump_diode_source_on_o};

  // ==========================================================
  // Checks
  // ==========================================================
  a_ext_stop_ends: assert property (@(posedge clk_i) disable iff (rst_i)
    laser_on_o && ext_mode && mode_q && !stop_i |=> !laser_on_o && end_pulse_o)
    else $error("stop opened but output continued");

  a_panel_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    laser_on_o && !ext_mode && btn_rise |=> !laser_on_o)
    else $error("panel press did not stop output");

  a_pump_warm: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl[lih_pkg::CTRL_PUMP] && temp_ok_i |=> pump_diode_source_on_o)
    else $error("pump-on withheld while warm");

  a_pump_cold: assert property (@(posedge clk_i) disable iff (rst_i)
    !temp_ok_i |=> !pump_diode_source_on_o)
    else $error("pump-on while cold");

  a_ready_sched: assert property (@(posedge clk_i) disable iff (rst_i)
    !acc[0] |=> !ready_o)
    else $error("ready without valid schedule");

  a_ready_cool: assert property (@(posedge clk_i) disable iff (rst_i)
    cool_cnt != 16'h0000 |=> !ready_o)
    else $error("ready during cooldown");

  a_ready_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    (pump_diode_source_on_o && acc[0] && cool_cnt == 16'h0000 && !two_beam
     && state == lih_pkg::LIH_IDLE)[*2] |-> ready_o)
    else $error("ready not given after preparation");

  a_ready_cond: assert property (@(posedge clk_i) disable iff (rst_i)
    two_beam && !ctrl[lih_pkg::CTRL_COND] |=> !ready_o)
    else $error("two-beam ready without conditional input");

  a_pulse_width: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(end_pulse_o) |-> pw_cnt == $past(pw_ticks))
    else $error("end pulse width not loaded");

  a_pulse_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    end_pulse_o && pw_cnt != 9'h000 |=> end_pulse_o)
    else $error("end pulse dropped early");

  a_judge_ok: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(end_pulse_o) |-> energy_ok_o == $past(in_limits))
    else $error("monitor judgment wrong");

  a_osc_delay: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(laser_on_o) |-> $past(state) == lih_pkg::LIH_DELAY && $past(dly_cnt) == 12'h000)
    else $error("oscillation without full delay");

  a_single_beam: assert property (@(posedge clk_i) disable iff (rst_i)
    single_variant_i |=> output_path_one_o && !output_path_two_o)
    else $error("variant used second beam");

endmodule : lih_top

`default_nettype wire

/* tb/lih_plc_model.sv */
/*
  Controller model that drives the contact inputs of the sequencer.
  Assumes the bench calls its tasks from the edge of the shared clock.
*/
`timescale 1ns/1ps
`default_nettype none

module lih_plc_model #(
  parameter int unsigned TICK_CYC = 4
) (
  input  wire logic clk_i,
  input  wire logic ready_i,
  output logic      ctrl_ext_o,
  output logic      start_o,
  output logic      stop_o,
  output logic      schedule_o,
  output logic      beam_sel_o
);
  // Gaps in 0.1 ms ticks
  localparam int unsigned MODE_GAP = 20 * TICK_CYC;
  localparam int unsigned SHUT_GAP = 1500 * TICK_CYC;

  initial
  begin
    ctrl_ext_o = 1'b0;
    start_o    = 1'b0;
    stop_o     = 1'b1;
    schedule_o = 1'b0;
    beam_sel_o = 1'b0;
  end

  task automatic set_mode(input logic ext);
    @(posedge clk_i);
    ctrl_ext_o <= ext;
    repeat (MODE_GAP) @(posedge clk_i);
  endtask : set_mode

  task automatic set_sched(input logic s);
    @(posedge clk_i);
    schedule_o <= s;
  endtask : set_sched

  task automatic select_beam(input logic b);
    @(posedge clk_i);
    beam_sel_o <= b;
    repeat (SHUT_GAP) @(posedge clk_i);
  endtask : select_beam

  task automatic fire(output bit ok);
    int n;
    n = 0;
    @(posedge clk_i);
    while (ready_i !== 1'b1 && n < 20000)
    begin
      @(posedge clk_i);
      n++;
    end
    ok = (ready_i === 1'b1);
    if (ok)
      start_o <= 1'b1;
  endtask : fire

  // Open stop ends output; start released with it
  task automatic halt();
    @(posedge clk_i);
    stop_o  <= 1'b0;
    start_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    stop_o  <= 1'b1;
  endtask : halt
endmodule : lih_plc_model
`default_nettype wire

/* tb/tb.sv */
/*
  Self-checking bench for the laser I/O handshake sequencer.
  Assumes lih_pkg, lih_top and the controller model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int T   = 4;
  localparam int OSC = 8;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic        panel_btn_i = 1'b0, single_variant_i = 1'b0, temp_ok_i = 1'b0;
  logic [15:0] energy_i = 16'h0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, ctrl_ext_i, start_i, stop_i, schedule_i, beam_sel_i;
  logic        pump_diode_source_on_o, ready_o, laser_on_o, output_path_one_o, output_path_two_o;
  logic        end_pulse_o, pass_pulse_o, fail_pulse_o, energy_ok_o;
  int          mismatches = 0;
  int          checks_done = 0;
  int          n;

  always #12.5 clk_i = ~clk_i;

  lih_top #(.TICK_CYC(T), .OSC_DLY_CYC(OSC)) dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .ctrl_ext_i, .start_i, .stop_i, .panel_btn_i, .schedule_i,
    .beam_sel_i, .single_variant_i, .temp_ok_i, .energy_i, .pump_diode_source_on_o,
    .ready_o, .laser_on_o, .output_path_one_o, .output_path_two_o, .end_pulse_o,
    .pass_pulse_o, .fail_pulse_o, .energy_ok_o);

  lih_plc_model #(.TICK_CYC(T)) plc (
    .clk_i, .ready_i(ready_o), .ctrl_ext_o(ctrl_ext_i), .start_o(start_i),
    .stop_o(stop_i), .schedule_o(schedule_i), .beam_sel_o(beam_sel_i));

  task automatic stop_test();
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic chk_rng(input int v, input int lo, input int hi);
    chk({31'h0, (v >= lo && v <= hi)}, 32'h1);
  endtask : chk_rng

  function automatic logic sig(input int w);
    return (w == 0) ? ready_o : (w == 1) ? laser_on_o : end_pulse_o;
  endfunction : sig

  // Bounded wait, counts edges
  task automatic wait_for(input int w, input logic v, input int lim, output int c);
    c = 0;
    while (sig(w) !== v && c < lim)
    begin
      @(posedge clk_i);
      c++;
    end
  endtask : wait_for

  task automatic wb_io(input logic we, input logic [3:0] adr, input logic [31:0] d, output logic [31:0] q);
    int c;
    c = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && c < 50)
    begin
      @(posedge clk_i);
      c++;
    end
    if (wb_ack_o !== 1'b1)
      mismatches++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb_io

  task automatic wb_wr(input logic [3:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb_io(1'b1, adr, d, q);
  endtask : wb_wr

  task automatic wb_rd_chk(input logic [3:0] adr, input logic [31:0] exp);
    logic [31:0] q;
    wb_io(1'b0, adr, 32'h0, q);
    chk(q, exp);
  endtask : wb_rd_chk

  task automatic press();
    @(posedge clk_i);
    panel_btn_i <= 1'b1;
    @(posedge clk_i);
    panel_btn_i <= 1'b0;
  endtask : press

  // One external output: acceptance, oscillation, end pulse and judgment
  task automatic shot(input logic [9:0] ctrl, input int acc, input int pw, input logic [15:0] en,
                      input logic ok);
    int  c;
    bit  r;
    wb_wr(lih_pkg::ADDR_CTRL, {22'h0, ctrl});
    energy_i <= en;
    plc.fire(r);
    chk({31'h0, r}, 32'h1);
    wait_for(1, 1'b1, acc * T + 100, c);
    chk_rng(c, (acc - 1) * T, acc * T + OSC + 6);
    plc.halt();
    chk({30'h0, laser_on_o, end_pulse_o}, 32'h1);
    chk({29'h0, energy_ok_o, pass_pulse_o, fail_pulse_o}, ok ? 32'h6 : 32'h1);
    wait_for(2, 1'b0, pw * T + 100, c);
    chk_rng(c + 2, pw * T - T, (pw + 2) * T);
  endtask : shot

  initial
  begin
    #(25 * 80000);
    mismatches++;
    stop_test();
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_rd_chk(lih_pkg::ADDR_CTRL, {22'h0, lih_pkg::CTRL_RST});
    wb_rd_chk(lih_pkg::ADDR_LIMITS, lih_pkg::LIMITS_RST);
    wb_rd_chk(lih_pkg::ADDR_COOL, 32'h0);
    wb_wr(4'h2, 32'hffff_ffff);
    wb_rd_chk(4'h2, 32'h0);
    wb_wr(lih_pkg::ADDR_LIMITS, 32'h0200_0100);
    wb_rd_chk(lih_pkg::ADDR_LIMITS, 32'h0200_0100);
    wb_wr(lih_pkg::ADDR_CTRL, 32'h031);
    repeat (4) @(posedge clk_i);
    chk({31'h0, pump_diode_source_on_o}, 32'h0);
    temp_ok_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, pump_diode_source_on_o}, 32'h1);
    plc.set_mode(1'b1);
    chk({31'h0, ready_o}, 32'h0);
    plc.set_sched(1'b1);
    wait_for(0, 1'b1, 600, n);
    chk_rng(n, 39 * T, 40 * T + 20);
    wb_rd_chk(lih_pkg::ADDR_STATUS, 32'h0000_001b);
    wb_wr(lih_pkg::ADDR_STATUS, 32'h0);
    wb_rd_chk(lih_pkg::ADDR_STATUS, 32'h0000_001b);
    plc.select_beam(1'b0);
    chk({30'h0, output_path_one_o, output_path_two_o}, 32'h2);
    shot(10'h031, 40, 200, 16'h0100, 1'b1);
    shot(10'h101, 1, 300, 16'h0201, 1'b0);
    shot(10'h251, 160, 400, 16'h0200, 1'b1);
    shot(10'h011, 10, 200, 16'h00ff, 1'b0);
    shot(10'h021, 20, 200, 16'h0180, 1'b1);
    shot(10'h041, 80, 200, 16'h0180, 1'b1);
    wb_wr(lih_pkg::ADDR_COOL, 32'h0000_0200);
    wb_rd_chk(lih_pkg::ADDR_COOL, 32'h0000_0200);
    shot(10'h033, 40, 200, 16'h0150, 1'b1);
    wait_for(0, 1'b1, 600 * T, n);
    chk_rng(n, 300 * T, 520 * T);
    wb_wr(lih_pkg::ADDR_CTRL, 32'h035);
    repeat (4) @(posedge clk_i);
    chk({31'h0, ready_o}, 32'h0);
    plc.select_beam(1'b1);
    chk({30'h0, output_path_one_o, output_path_two_o}, 32'h1);
    shot(10'h03d, 40, 160, 16'h0150, 1'b1);
    plc.set_mode(1'b0);
    wb_wr(lih_pkg::ADDR_CTRL, 32'h031);
    wait_for(0, 1'b1, 600, n);
    press();
    wait_for(1, 1'b1, 100, n);
    chk_rng(n, OSC - 1, OSC + 6);
    press();
    wait_for(2, 1'b1, 20, n);
    chk_rng(n, 0, 4);
    chk({31'h0, laser_on_o}, 32'h0);
    wait_for(2, 1'b0, 1000, n);
    single_variant_i <= 1'b1;
    wb_wr(lih_pkg::ADDR_CTRL, 32'h03d);
    repeat (3) @(posedge clk_i);
    chk({30'h0, output_path_one_o, output_path_two_o}, 32'h2);
    stop_test();
  end
endmodule : tb
`default_nettype wire
